// File: rtl/ldsc_pkg.sv
// Constants shared by the serial host port and chain logic
package ldsc_pkg;

  localparam int DATA_W = 8;
  localparam int DISP_AW = 14;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam int NUM_REGS = 16;
  localparam int PIN_W = 6;

  // Accepted frame lengths and bit counter
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_CMD = 5'h10;
  localparam logic [4:0] LEN_DIRECT = 5'h18;
  localparam logic [4:0] CNT_SAT = 5'h19;

  // Field positions inside the shifted frame
  localparam int POS_RW16 = 15;
  localparam int POS_AI = 14;
  localparam int POS_LG = 13;
  localparam int POS_RSV = 12;
  localparam int POS_REG_LO = 8;
  localparam int POS_REG_HI = 11;
  localparam int POS_RW24 = 23;
  localparam int POS_MADDR_LO = 8;
  localparam int POS_MADDR_HI = 21;

  // Register indices
  localparam logic [3:0] REG_DRV_ADDR = 4'h0;
  localparam logic [3:0] REG_LOCAL_LAST = 4'h7;
  localparam logic [3:0] REG_DRV_IND = 4'h8;
  localparam logic [3:0] REG_DISP_LSB = 4'h9;
  localparam logic [3:0] REG_DISP_MSB = 4'hA;
  localparam logic [3:0] REG_PLANE = 4'hB;
  localparam logic [3:0] REG_PANEL = 4'hD;

  // Power-up values, register 0 in the lowest byte
  localparam logic [127:0] REG_RST =
    128'hFFFF3000_00000000_000000FF_FF800000;

  localparam int PLANE_AUTO_BIT = 6;

  // Chain timing in oscillator periods, chain clock cycles and system clock cycles
  localparam logic OSC_HALF_LAST = 1'b1;
  localparam logic [8:0] CHAIN_CYCLES = 9'h100;
  localparam logic [9:0] IRQ_OSC = 10'h200;
  localparam logic [2:0] ARM_CYCLES = 3'h4;

  // Readback falling edges
  localparam logic [2:0] RB_LAST = 3'h7;

  // Pin vector order into the synchroniser
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_CHIN = 3;
  localparam int PIN_CHCLK = 4;
  localparam int PIN_OSC = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h01;

  typedef enum logic [1:0] {RB_IDLE, RB_FETCH, RB_ARM, RB_SHIFT} ldsc_rb_e;
  typedef enum logic [1:0] {CFG_ARM, CFG_RUN, CFG_DONE} ldsc_cfg_e;

endpackage : ldsc_pkg

// File: rtl/ldsc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ldsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1, s2, s3, held;
      logic next_held;
      // Only stages two and three decide a change
      always_comb begin
        next_held = held;
        if (s2 == s3) begin
          next_held = s3;
        end
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          s1 <= RESET_VAL[i];
          s2 <= RESET_VAL[i];
          s3 <= RESET_VAL[i];
          held <= RESET_VAL[i];
        end else begin
          s1 <= pinIn[i];
          s2 <= s1;
          s3 <= s2;
          held <= next_held;
        end
      end
      assign pinOut[i] = held;
    end
  endgenerate

endmodule : ldsc_sync

// File: rtl/ldsc_mem.sv
// Display memory slice, one write port, registered read
`timescale 1ns/100ps
module ldsc_mem
  import ldsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [MEM_AW-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [MEM_AW-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] store [MEM_DEPTH];

  // No reset: contents are retained, not defined, at power-up
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule : ldsc_mem

// File: rtl/ldsc_host_chain.sv
// Serial host command port and chain address allocation
//
// Function
// R1: Byte frame writes display at indirect address
// R2: Display indirect address increments after byte write
// R3: Command frame accesses registers, global or selected
// R4: Command read answered by selected driver only; global register reads are answered by address zero instead
// R5: Command bit requests driver indirect increment
// R6: Direct frame uses its own memory address
// R7: Shift while select low, sample rising clock
// R8: Data out released except during readback
// R9: Discard frames not 8, 16 or 24 bits
// R10: Last eight bits are data, MSB first
// R11: First bit high means read
// R12: Host shifts command, raises select, clocks byte
// R13: Release data out after eighth falling edge
// R14: Select falling aborts readback and releases
// R15: Host keeps clock low around select edges; the host model raises select with the clock still high
// R16: Read command trailing byte ignored
// R17: Chain output low, rises n+1.5 periods later
// R18: Chain clock osc/4, driven by master only
// R19: Chain clock runs 256 cycles per configuration
// R20: Auto plane change pulses chain output low
// R21: Global register writes reach every driver
// R22: Global reads answered only by address zero
// R23: Count bits while selected, decode at select rise
`timescale 1ns/100ps
module ldsc_host_chain
  import ldsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic doutOeN,
  input wire logic chainIn,
  output logic chainOut,
  input wire logic chainClockIn,
  output logic chainClockOut,
  output logic chainClockOeN,
  input wire logic multiplexOscillator,
  input wire logic planeChangeStrobe,
  output logic [DATA_W-1:0] driverAddress,
  output logic [DATA_W-1:0] panelConfig,
  output logic [DATA_W-1:0] planeCounter,
  output logic configBusy
);

  // Pin synchronisation and edges
  logic [PIN_W-1:0] pinRaw, pinF, pinPrev;
  logic csF, dinF, chainInF;
  logic csFall, csRise, sclkRise, sclkFall, oscRise;

  assign pinRaw = {multiplexOscillator, chainClockIn, chainIn, din, sclk, csN};

  ldsc_sync #(.WIDTH(PIN_W), .RESET_VAL(PIN_RST)) ldsc_sync_inst (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(pinRaw),
    .pinOut(pinF)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinPrev <= PIN_RST;
    end else begin
      pinPrev <= pinF;
    end
  end

  assign csF = pinF[PIN_CS];
  assign dinF = pinF[PIN_DIN];
  assign chainInF = pinF[PIN_CHIN];
  assign csFall = pinPrev[PIN_CS] && !pinF[PIN_CS];
  assign csRise = !pinPrev[PIN_CS] && pinF[PIN_CS];
  assign sclkRise = !pinPrev[PIN_SCLK] && pinF[PIN_SCLK];
  assign sclkFall = pinPrev[PIN_SCLK] && !pinF[PIN_SCLK];
  assign oscRise = !pinPrev[PIN_OSC] && pinF[PIN_OSC];

  // Frame shifter
  logic [23:0] shiftReg, next_shiftReg;
  logic [4:0] bitCnt, next_bitCnt;

  always_comb begin
    next_shiftReg = shiftReg;
    next_bitCnt = bitCnt;
    if (csFall) begin
      next_bitCnt = '0;
    end else if (!csF && sclkRise) begin // R7 R23
      next_shiftReg = {shiftReg[22:0], dinF}; // R10
      if (bitCnt != CNT_SAT) begin
        next_bitCnt = bitCnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shiftReg <= '0;
      bitCnt <= '0;
    end else begin
      shiftReg <= next_shiftReg;
      bitCnt <= next_bitCnt;
    end
  end

  // Frame decode, only at select rise
  logic isByte, isCmd, isDirect;
  logic cmdRead, cmdRsv, cmdLocal, cmdLg, cmdAi;
  logic [3:0] regIdx;
  logic [DATA_W-1:0] myAddr, driverInd, regRead;
  logic [DISP_AW-1:0] dispInd, directAddr;
  logic selected, regWrHit, regRdHit, aiStep;
  logic memWrEn, memRdHit, byteHit, directHit;
  logic [MEM_AW-1:0] memWrAddr;
  logic [DATA_W-1:0] memRdData;

  assign isByte = csRise && (bitCnt == LEN_BYTE); // R9 R23
  assign isCmd = csRise && (bitCnt == LEN_CMD); // R9
  assign isDirect = csRise && (bitCnt == LEN_DIRECT); // R9
  assign cmdRead = shiftReg[POS_RW16]; // R11
  assign cmdAi = shiftReg[POS_AI];
  assign cmdLg = shiftReg[POS_LG];
  assign cmdRsv = shiftReg[POS_RSV];
  assign regIdx = shiftReg[POS_REG_HI:POS_REG_LO];
  assign cmdLocal = regIdx <= REG_LOCAL_LAST;
  assign selected = driverInd == myAddr;
  assign directAddr = shiftReg[POS_MADDR_HI:POS_MADDR_LO];

  // Local registers honour the local/global bit; globals reach all
  assign regWrHit = isCmd && !cmdRead && !cmdRsv &&
    (!cmdLocal || cmdLg || selected); // R3 R21
  // Local reads follow the indirect pointer, globals use address 0
  assign regRdHit = isCmd && cmdRead && !cmdRsv &&
    (cmdLocal ? selected : (myAddr == '0)); // R4 R22
  // Every driver steps its copy so the pointer stays coherent
  assign aiStep = isCmd && !cmdRsv && cmdLocal && cmdAi &&
    (cmdRead || !cmdLg); // R5

  assign byteHit = dispInd[DISP_AW-1:MEM_AW] == myAddr; // R1
  assign directHit = directAddr[DISP_AW-1:MEM_AW] == myAddr; // R6
  assign memWrEn = (isByte && byteHit) ||
    (isDirect && !shiftReg[POS_RW24] && directHit); // R1 R6 R11
  assign memWrAddr = isByte ? dispInd[MEM_AW-1:0] :
    directAddr[MEM_AW-1:0];
  assign memRdHit = isDirect && shiftReg[POS_RW24] && directHit; // R6

  ldsc_mem ldsc_mem_inst (
    .sys_clk(sys_clk),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(shiftReg[DATA_W-1:0]),
    .rdAddr(directAddr[MEM_AW-1:0]),
    .rdData(memRdData)
  );

  // Register file
  logic [DATA_W-1:0] regFile [NUM_REGS];
  logic [DATA_W-1:0] next_regFile [NUM_REGS];
  logic [DATA_W-1:0] next_driverInd;
  logic [DISP_AW-1:0] next_dispInd;
  logic panelWrite;

  always_comb begin
    if (regIdx == REG_DRV_ADDR) begin
      regRead = myAddr;
    end else if (regIdx == REG_DRV_IND) begin
      regRead = driverInd;
    end else if (regIdx == REG_DISP_LSB) begin
      regRead = dispInd[DATA_W-1:0];
    end else if (regIdx == REG_DISP_MSB) begin
      regRead = {2'b00, dispInd[DISP_AW-1:DATA_W]};
    end else begin
      regRead = regFile[regIdx];
    end
  end

  always_comb begin
    next_regFile = regFile;
    next_driverInd = driverInd;
    next_dispInd = dispInd;
    if (isByte) begin
      next_dispInd = dispInd + 14'h0001; // R2
    end
    if (regWrHit) begin
      if (regIdx == REG_DRV_IND) begin
        next_driverInd = shiftReg[DATA_W-1:0];
      end else if (regIdx == REG_DISP_LSB) begin
        next_dispInd[DATA_W-1:0] = shiftReg[DATA_W-1:0];
      end else if (regIdx == REG_DISP_MSB) begin
        next_dispInd[DISP_AW-1:DATA_W] = shiftReg[DISP_AW-DATA_W-1:0];
      end else if (regIdx != REG_DRV_ADDR) begin
        next_regFile[regIdx] = shiftReg[DATA_W-1:0]; // R3 R21
      end
    end
    if (aiStep) begin
      next_driverInd = driverInd + 8'h01; // R5
    end
  end

  assign panelWrite = regWrHit && (regIdx == REG_PANEL);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NUM_REGS; k++) begin
        regFile[k] <= REG_RST[k*DATA_W +: DATA_W];
      end
      driverInd <= '0;
      dispInd <= '0;
    end else begin
      regFile <= next_regFile;
      driverInd <= next_driverInd;
      dispInd <= next_dispInd;
    end
  end

  // Readback; the trailing byte of a read was never stored
  ldsc_rb_e rbState, next_rbState;
  logic [DATA_W-1:0] txByte, next_txByte;
  logic [2:0] rbCnt, next_rbCnt;

  always_comb begin
    next_rbState = rbState;
    next_txByte = txByte;
    next_rbCnt = rbCnt;
    case (rbState)
      RB_IDLE: begin
        if (regRdHit) begin // R16
          next_txByte = regRead;
          next_rbCnt = '0;
          next_rbState = RB_ARM;
        end else if (memRdHit) begin // R16
          next_rbState = RB_FETCH;
        end
      end
      RB_FETCH: begin
        next_txByte = memRdData;
        next_rbCnt = '0;
        next_rbState = RB_ARM;
      end
      RB_ARM: begin
        // The clock fall that closes the command is not a data edge
        if (csFall) begin
          next_rbState = RB_IDLE; // R14
        end else if (sclkFall) begin
          next_rbState = RB_SHIFT; // R12
        end
      end
      RB_SHIFT: begin
        if (csFall) begin
          next_rbState = RB_IDLE; // R14
        end else if (sclkFall) begin
          if (rbCnt == RB_LAST) begin
            next_rbState = RB_IDLE; // R13
          end else begin
            next_txByte = {txByte[DATA_W-2:0], 1'b0}; // R12
            next_rbCnt = rbCnt + 3'h1;
          end
        end
      end
      default: begin
        next_rbState = RB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rbState <= RB_IDLE;
      txByte <= '0;
      rbCnt <= '0;
    end else begin
      rbState <= next_rbState;
      txByte <= next_txByte;
      rbCnt <= next_rbCnt;
    end
  end

  assign dout = txByte[DATA_W-1];
  assign doutOeN = !((rbState == RB_ARM) || (rbState == RB_SHIFT)); // R8

  // Chain configuration and plane interrupt
  ldsc_cfg_e cfgState, next_cfgState;
  logic [2:0] armCnt, next_armCnt;
  logic isMaster, next_isMaster;
  logic oscDiv, next_oscDiv;
  logic chainClk, next_chainClk;
  logic ccPrev, next_ccPrev, ccObs, ccRise, ccFall;
  logic [8:0] cfgFalls, next_cfgFalls;
  logic addrFound, next_addrFound;
  logic pendRaise, next_pendRaise;
  logic chainLevel, next_chainLevel;
  logic [DATA_W-1:0] next_myAddr;
  logic [9:0] irqCnt, next_irqCnt;

  // Master counts its own clock; others count the shared pin
  assign ccObs = isMaster ? chainClk : pinF[PIN_CHCLK];
  assign ccRise = !ccPrev && ccObs;
  assign ccFall = ccPrev && !ccObs;

  always_comb begin
    next_cfgState = cfgState;
    next_armCnt = armCnt;
    next_isMaster = isMaster;
    next_oscDiv = oscDiv;
    next_chainClk = chainClk;
    next_cfgFalls = cfgFalls;
    next_addrFound = addrFound;
    next_pendRaise = pendRaise;
    next_chainLevel = chainLevel;
    next_myAddr = myAddr;
    next_irqCnt = irqCnt;
    next_ccPrev = ccObs;
    case (cfgState)
      CFG_ARM: begin
        // Wait for the chain input to settle through the synchroniser
        next_chainLevel = 1'b0; // R17
        // Idle low; a stale pin level at the master switch is no fall
        next_ccPrev = 1'b0;
        next_chainClk = 1'b0;
        next_oscDiv = 1'b0;
        next_cfgFalls = '0;
        next_addrFound = 1'b0;
        next_pendRaise = 1'b0;
        next_armCnt = armCnt + 3'h1;
        if (armCnt == ARM_CYCLES) begin
          next_isMaster = chainInF; // R18
          next_cfgState = CFG_RUN;
        end
      end
      CFG_RUN: begin
        if (isMaster && oscRise) begin
          next_oscDiv = !oscDiv;
          if (oscDiv == OSC_HALF_LAST) begin
            next_chainClk = !chainClk; // R18
          end
        end
        if (ccFall) begin
          next_cfgFalls = cfgFalls + 9'h001;
          if (!addrFound && chainInF) begin
            next_myAddr = cfgFalls[DATA_W-1:0]; // R17
            next_addrFound = 1'b1;
            next_pendRaise = 1'b1;
          end
          if (next_cfgFalls == CHAIN_CYCLES) begin
            next_cfgState = CFG_DONE; // R19
          end
        end
        if (ccRise && pendRaise) begin
          next_chainLevel = 1'b1; // R17
          next_pendRaise = 1'b0;
        end
      end
      CFG_DONE: begin
        next_chainClk = 1'b0;
      end
      default: begin
        next_cfgState = CFG_ARM;
      end
    endcase
    if (panelWrite) begin
      next_cfgState = CFG_ARM; // R19
      next_armCnt = '0;
    end
    if (planeChangeStrobe && regFile[REG_PLANE][PLANE_AUTO_BIT]) begin
      next_irqCnt = IRQ_OSC; // R20
    end else if (oscRise && (irqCnt != '0)) begin
      next_irqCnt = irqCnt - 10'h001; // R20
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfgState <= CFG_ARM;
      armCnt <= '0;
      isMaster <= 1'b0;
      oscDiv <= 1'b0;
      chainClk <= 1'b0;
      ccPrev <= 1'b0;
      cfgFalls <= '0;
      addrFound <= 1'b0;
      pendRaise <= 1'b0;
      chainLevel <= 1'b0;
      myAddr <= '0;
      irqCnt <= '0;
    end else begin
      cfgState <= next_cfgState;
      armCnt <= next_armCnt;
      isMaster <= next_isMaster;
      oscDiv <= next_oscDiv;
      chainClk <= next_chainClk;
      ccPrev <= next_ccPrev;
      cfgFalls <= next_cfgFalls;
      addrFound <= next_addrFound;
      pendRaise <= next_pendRaise;
      chainLevel <= next_chainLevel;
      myAddr <= next_myAddr;
      irqCnt <= next_irqCnt;
    end
  end

  assign chainOut = chainLevel && (irqCnt == '0); // R17 R20
  assign chainClockOut = chainClk;
  assign chainClockOeN = !isMaster; // R18
  assign driverAddress = myAddr;
  assign panelConfig = regFile[REG_PANEL];
  assign planeCounter = regFile[REG_PLANE];
  assign configBusy = cfgState != CFG_DONE;

endmodule : ldsc_host_chain

// File: tb/ldsc_host_chain_chk.sv
// Concurrent checks on the host port and chain link pins
`timescale 1ns/100ps
module ldsc_host_chain_chk
  import ldsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic dout,
  input wire logic doutOeN,
  input wire logic chainOut,
  input wire logic chainClockOut,
  input wire logic multiplexOscillator,
  input wire logic planeChangeStrobe,
  input wire logic [DATA_W-1:0] driverAddress,
  input wire logic [DATA_W-1:0] panelConfig,
  input wire logic [DATA_W-1:0] planeCounter,
  input wire logic configBusy
);
  logic [1:0] hiOsc;
  logic [8:0] ckRise;
  logic [9:0] irqOsc;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Raw pin edges; the design sees them a few cycles later
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hiOsc <= 2'h0;
      ckRise <= 9'h000;
      irqOsc <= 10'h000;
    end else begin
      if (!chainClockOut)
        hiOsc <= 2'h0;
      else if ($rose(multiplexOscillator))
        hiOsc <= hiOsc + 2'h1;
      if ($rose(configBusy))
        ckRise <= 9'h000;
      else if ($rose(chainClockOut))
        ckRise <= ckRise + 9'h001;
      if (chainOut)
        irqOsc <= 10'h000;
      else if ($rose(multiplexOscillator))
        irqOsc <= irqOsc + 10'h001;
    end
  end
  sequence csDrop;
    !doutOeN && csN ##1 !csN;
  endsequence
  sequence rbLive;
    !doutOeN && sclk;
  endsequence
  rb_start_a: assert property (
    $fell(doutOeN) |-> csN && $past(csN, 3))
    else $error("dout enabled inside a frame");
  rb_abort_a: assert property (
    csDrop |-> ##[1:6] doutOeN)
    else $error("readback not aborted");
  rb_idle_a: assert property (
    (!csN) [*8] |-> doutOeN)
    else $error("dout driven while selected");
  rb_stable_a: assert property (
    rbLive ##1 rbLive |-> $stable(dout))
    else $error("dout moved while clock high");
  ck_half_a: assert property (
    $fell(chainClockOut) |-> hiOsc == 2'h2)
    else $error("chain clock not osc/4");
  ck_count_a: assert property (
    $fell(configBusy) |-> ckRise == 9'h100 && !chainClockOut)
    else $error("chain clock count wrong");
  cfg_start_a: assert property (
    $changed(panelConfig) || $rose(resetn)
      |-> ##[0:8] (configBusy && !chainOut))
    else $error("config did not start");
  addr_rise_a: assert property (
    $rose(chainOut) && configBusy
      |-> ##[0:2] (ckRise == {1'b0, driverAddress} + 9'h002))
    else $error("chain output rose at wrong time");
  irq_start_a: assert property (
    planeChangeStrobe && planeCounter[PLANE_AUTO_BIT] && !configBusy
      |=> !chainOut)
    else $error("plane interrupt missing");
  irq_len_a: assert property (
    $rose(chainOut) && !configBusy
      |-> irqOsc >= 10'h1FF && irqOsc <= 10'h201)
    else $error("plane interrupt length wrong");
  cfg_decode_a: assert property (
    $changed(panelConfig) |-> csN && $past(csN, 2))
    else $error("register changed inside a frame");
endmodule : ldsc_host_chain_chk
bind ldsc_host_chain ldsc_host_chain_chk ldsc_host_chain_chk_inst (
  .sys_clk, .resetn, .csN, .sclk, .dout, .doutOeN, .chainOut,
  .chainClockOut, .multiplexOscillator, .planeChangeStrobe,
  .driverAddress, .panelConfig, .planeCounter, .configBusy);

// File: tb/ldsc_host.sv
// Host processor model driving the serial command port
`timescale 1ns/100ps
module ldsc_host (
  input wire logic sys_clk,
  input wire logic dout,
  input wire logic doutOeN,
  output logic csN,
  output logic sclk,
  output logic din
);
  // Half period in cycles; readback through the pin filter needs at least 5
  int half = 6;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic hold(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : hold
  task automatic frame(input logic [31:0] b, input int len);
    sclk = 1'b0;
    hold(half);
    csN = 1'b0;
    for (int i = len - 1; i >= 0; i--) begin
      din = b[i];
      hold(half);
      sclk = 1'b1;
      hold(half);
      if (i > 0)
        sclk = 1'b0;
    end
    csN = 1'b1;
    hold(half);
    sclk = 1'b0;
    din = ~din;
    hold(half);
  endtask : frame
  task automatic readback(output logic [7:0] d, output logic [7:0] drv);
    drv = 8'h00;
    hold(half);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      d[i] = dout;
      drv = drv + {7'h00, ~doutOeN};
      hold(half);
      sclk = 1'b0;
      hold(half);
    end
    hold(half);
  endtask : readback
  task automatic abort(input int k, output logic oe);
    hold(half);
    repeat (k) begin
      sclk = 1'b1;
      hold(half);
      sclk = 1'b0;
      hold(half);
    end
    csN = 1'b0;
    hold(8);
    oe = doutOeN;
    csN = 1'b1;
    hold(2 * half);
  endtask : abort
endmodule : ldsc_host

// File: tb/ldsc_host_chain_tb_top.sv
// Self-checking bench for the serial host port and chain link
`timescale 1ns/100ps
module ldsc_host_chain_tb_top;
  logic sys_clk, resetn, osc, planeChangeStrobe;
  logic csN, sclk, din, dout, doutOeN, chainOut, chainClockOut;
  logic chainClockOeN, configBusy, chainClockIn, oe, chainIn, doutBus;
  logic [7:0] driverAddress, panelConfig, planeCounter, d, drv;
  logic ckPrev = 1'b0;
  logic coPrev = 1'b0;
  logic busyPrev = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int riseCnt = 0;
  int riseAtOut = 0;
  int n;
  int badLen[7] = '{0, 7, 9, 15, 17, 23, 25};
  // Undriven shared clock reads back inverted, never a stale level
  assign chainClockIn = chainClockOeN ? ~chainClockOut : chainClockOut;
  // Released data line reads back inverted as well
  assign doutBus = doutOeN ? ~dout : dout;
  ldsc_host_chain ldsc_host_chain_inst (.sys_clk, .resetn, .csN, .sclk,
    .din, .dout, .doutOeN, .chainIn, .chainOut, .chainClockIn,
    .chainClockOut, .chainClockOeN, .multiplexOscillator(osc),
    .planeChangeStrobe, .driverAddress, .panelConfig, .planeCounter,
    .configBusy);
  ldsc_host ldsc_host_inst (.sys_clk, .dout(doutBus), .doutOeN, .csN,
    .sclk, .din);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    osc = 1'b0;
    forever begin
      repeat (6) @(negedge sys_clk);
      osc = ~osc;
    end
  end
  always @(posedge sys_clk) begin
    ckPrev <= chainClockOut;
    coPrev <= chainOut;
    busyPrev <= configBusy;
    if (configBusy && !busyPrev)
      riseCnt <= 0;
    else if (chainClockOut && !ckPrev)
      riseCnt <= riseCnt + 1;
    if (chainOut && !coPrev && configBusy)
      riseAtOut <= riseCnt;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [31:0] b, input int len, input logic [7:0] e);
    ldsc_host_inst.frame(b, len);
    ldsc_host_inst.readback(d, drv);
    chk(d, e);
    chk(drv, 8'h08);
    chk({7'h00, doutOeN}, 8'h01);
  endtask : rd
  task automatic waitCfg();
    n = 0;
    while (configBusy !== 1'b0 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h00, configBusy}, 8'h00);
    chk(riseCnt == 256 ? 8'h01 : 8'h00, 8'h01);
    chk(riseAtOut[7:0], 8'h02);
    chk(driverAddress, 8'h00);
    chk({7'h00, chainOut}, 8'h01);
  endtask : waitCfg
  task automatic strobe(input logic exp);
    planeChangeStrobe = 1'b1;
    @(negedge sys_clk);
    planeChangeStrobe = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, chainOut}, {7'h00, exp});
  endtask : strobe
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    resetn = 1'b0;
    planeChangeStrobe = 1'b0;
    chainIn = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk({7'h00, doutOeN}, 8'h01);
    chk({7'h00, configBusy}, 8'h01);
    resetn = 1'b1;
    waitCfg();
    chk({7'h00, chainClockOeN}, 8'h00);
    ldsc_host_inst.frame(24'h0B5A, 16);
    chk(planeCounter, 8'h5A);
    rd(24'h8BC3, 16, 8'h5A);
    chk(planeCounter, 8'h5A);
    foreach (badLen[i]) begin
      ldsc_host_inst.frame(32'h000B11, badLen[i]);
      chk(planeCounter, 8'h5A);
    end
    ldsc_host_inst.frame(24'h1B22, 16);
    chk(planeCounter, 8'h5A);
    ldsc_host_inst.frame(24'h0905, 16);
    ldsc_host_inst.frame(24'h0A00, 16);
    ldsc_host_inst.frame(24'hA5, 8);
    ldsc_host_inst.frame(24'h3C, 8);
    rd(24'h8900, 16, 8'h07);
    rd(24'h8005FF, 24, 8'hA5);
    rd(24'h8006FF, 24, 8'h3C);
    ldsc_host_inst.frame(24'h001077, 24);
    rd(24'h8010FF, 24, 8'h77);
    rd(24'h8900, 16, 8'h07);
    ldsc_host_inst.frame(24'h4196, 16);
    rd(24'h8800, 16, 8'h01);
    ldsc_host_inst.frame(24'h81AA, 16);
    ldsc_host_inst.readback(d, drv);
    chk(drv, 8'h00);
    ldsc_host_inst.frame(24'h0155, 16);
    ldsc_host_inst.frame(24'h0800, 16);
    rd(24'h8100, 16, 8'h96);
    ldsc_host_inst.frame(24'h2177, 16);
    rd(24'h8100, 16, 8'h77);
    ldsc_host_inst.frame(24'h8B00, 16);
    ldsc_host_inst.abort(3, oe);
    chk({7'h00, oe}, 8'h01);
    ldsc_host_inst.half = 11;
    rd(24'h8B00, 16, 8'h5A);
    ldsc_host_inst.half = 6;
    ldsc_host_inst.frame(24'h0B00, 16);
    strobe(1'b1);
    ldsc_host_inst.frame(24'h0B40, 16);
    strobe(1'b0);
    n = 0;
    while (chainOut !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
    end
    chk((n >= 6120 && n <= 6165) ? 8'h01 : 8'h00, 8'h01);
    chainIn = 1'b0;
    ldsc_host_inst.frame(24'h0D31, 16);
    chk(panelConfig, 8'h31);
    chk({7'h00, configBusy}, 8'h01);
    chk({7'h00, chainClockOeN}, 8'h01);
    chk({7'h00, chainOut}, 8'h00);
    chainIn = 1'b1;
    ldsc_host_inst.frame(24'h0D32, 16);
    chk(panelConfig, 8'h32);
    waitCfg();
    chk({7'h00, chainClockOeN}, 8'h00);
    test_done();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
endmodule : ldsc_host_chain_tb_top
